// *** crc_generator.sv ***
// Checksum generator over a byte stream with processor, DMA and flash sources.
//
// Operation
// - Software picks a 16-bit or a 32-bit generator polynomial.
// - Generator values are 0x1021 for 16-bit and 0x04C11DB7 for 32-bit.
// - Streams or blocks are folded in byte by byte in arrival order.
// - Result is 16 or 32 bits wide, matching the chosen polynomial.
// - A zero remainder after data plus checksum is flagged.
// - DMA source folds in every byte passing the selected channel.
// - Flash source scans the whole flash or a chosen address range.
`timescale 1ns/100ps
module crc_generator #(
    parameter int ADDR_WIDTH = 17,
    parameter int FLASH_SIZE = 131072
) (
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  sys_rst,
    // Configuration
    input  wire logic                  polySel32,
    input  wire logic [1:0]            sourceSel,
    input  wire logic                  clearReq,
    // Processor byte input
    input  wire logic [7:0]            ioData,
    input  wire logic                  ioWrite,
    output logic                       ioReady,
    // DMA channel tap
    input  wire logic [7:0]            dmaData,
    input  wire logic                  dmaValid,
    output logic                       dmaReady,
    // Flash scanner control
    input  wire logic                  scanStart,
    input  wire logic                  scanWhole,
    input  wire logic [ADDR_WIDTH-1:0] scanFirst,
    input  wire logic [ADDR_WIDTH-1:0] scanLast,
    output logic                       scanBusy,
    output logic                       scanDone,
    // Flash read port
    output logic [ADDR_WIDTH-1:0]      flashAddr,
    output logic                       flashRead,
    input  wire logic [7:0]            flashData,
    // Result
    output logic [31:0]                checksum,
    output logic                       zeroRemainder,
    output logic                       busy
);
    crc_pkg::source_t src;
    crc_pkg::scan_t   scanState;
    crc_pkg::scan_t   next_scanState;

    logic [31:0]           crcState;
    logic [ADDR_WIDTH-1:0] scanAddr;
    logic [ADDR_WIDTH-1:0] scanEnd;
    logic                  flashValid;
    logic [7:0]            flashByte;

    // Read strobes wait here until the flash has answered.
    localparam int LAT = crc_pkg::FLASH_LAT;
    logic [LAT-1:0]        readPipe;

    // Source multiplexer in front of the buffer.
    logic [7:0] fifoInData;
    logic       fifoInValid;
    logic       fifoInReady;
    logic [7:0] fifoOutData;
    logic       fifoOutValid;

    assign src = crc_pkg::source_t'(sourceSel);

    wire selIo    = (src == crc_pkg::SRC_IO);
    wire selDma   = (src == crc_pkg::SRC_DMA);
    wire selFlash = (src == crc_pkg::SRC_FLASH);

    assign fifoInData  = selIo ? ioData :
                         selDma ? dmaData : flashByte;
    assign fifoInValid = (selIo & ioWrite) | (selDma & dmaValid) | (selFlash & flashValid);

    // Ready is combinational so that back-pressure reaches each source without a bubble.
    assign ioReady  = selIo & fifoInReady;
    assign dmaReady = selDma & fifoInReady;

    crc_fifo #(
        .WIDTH (crc_pkg::DATA_WIDTH),
        .DEPTH (crc_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .flush    (clearReq),
        .inData   (fifoInData),
        .inValid  (fifoInValid),
        .inReady  (fifoInReady),
        .outData  (fifoOutData),
        .outValid (fifoOutValid),
        .outReady (1'b1)
    );

    // Byte-wide update, most significant bit first, for either width.
    function automatic logic [31:0] crc_byte(
        input logic [31:0] cur,
        input logic [7:0]  din,
        input logic        wide
    );
        logic [31:0] c;
        logic        fb;
        c = cur;
        fb = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            if (wide) begin
                fb = c[31] ^ din[i];
                c = {c[30:0], 1'b0} ^ (fb ? crc_pkg::POLY32 : 32'h00000000);
            end else begin
                fb = c[15] ^ din[i];
                c = {16'h0000, c[14:0], 1'b0} ^ {16'h0000, (fb ? crc_pkg::POLY16 : 16'h0000)};
            end
        end
        return c;
    endfunction

    wire [31:0] next_crcState = crc_byte(crcState, fifoOutData, polySel32);
    wire [31:0] seedValue     = polySel32 ? crc_pkg::SEED : {16'h0000, crc_pkg::SEED[15:0]};
    wire [31:0] next_result   = polySel32 ? next_crcState : {16'h0000, next_crcState[15:0]};

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            crcState <= crc_pkg::CHECK_RESET;
        end else if (clearReq) begin
            crcState <= seedValue;
        end else if (fifoOutValid) begin
            crcState <= next_result;
        end
    end

    // Registered outputs follow the state one cycle later.
    wire [31:0] shownState = polySel32 ? crcState : {16'h0000, crcState[15:0]};
    wire        stateZero  = (shownState == 32'h00000000);
    wire        anyWork    = fifoOutValid | fifoInValid | (|readPipe)
                           | (scanState != crc_pkg::SCAN_IDLE);

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            checksum <= 32'h00000000;
        end else begin
            checksum <= shownState;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            zeroRemainder <= 1'b0;
        end else begin
            zeroRemainder <= stateZero;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            busy <= 1'b0;
        end else begin
            busy <= anyWork;
        end
    end

    // Flash scanner: one read per byte, the next read waits for buffer room.
    wire [ADDR_WIDTH-1:0] wholeLast = ADDR_WIDTH'(FLASH_SIZE - 1);
    wire                  lastByte  = (scanAddr == scanEnd);
    wire                  scanTake  = (scanState == crc_pkg::SCAN_IDLE) && scanStart;
    wire                  scanStep  = (scanState == crc_pkg::SCAN_WAIT) && !lastByte;

    always_comb begin
        next_scanState = scanState;
        case (scanState)
            crc_pkg::SCAN_IDLE: begin
                if (scanStart && selFlash) begin
                    next_scanState = crc_pkg::SCAN_REQ;
                end
            end
            crc_pkg::SCAN_REQ: begin
                if (fifoInReady) begin
                    next_scanState = crc_pkg::SCAN_WAIT;
                end
            end
            crc_pkg::SCAN_WAIT: begin
                next_scanState = lastByte ? crc_pkg::SCAN_DONE : crc_pkg::SCAN_REQ;
            end
            crc_pkg::SCAN_DONE: begin
                next_scanState = crc_pkg::SCAN_IDLE;
            end
            default: begin
                next_scanState = crc_pkg::SCAN_IDLE;
            end
        endcase
        if (clearReq || !selFlash) begin
            next_scanState = crc_pkg::SCAN_IDLE;
        end
    end

    // A read is only issued when the buffer can take its byte, so no byte is dropped.
    wire issueRead = (scanState == crc_pkg::SCAN_REQ) && fifoInReady && selFlash && !clearReq;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scanState <= crc_pkg::SCAN_IDLE;
        end else begin
            scanState <= next_scanState;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scanAddr <= '0;
            scanEnd  <= '0;
        end else if (scanTake) begin
            scanAddr <= scanWhole ? '0 : scanFirst;
            scanEnd  <= scanWhole ? wholeLast : scanLast;
        end else if (scanStep) begin
            scanAddr <= scanAddr + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            flashAddr <= '0;
            flashRead <= 1'b0;
        end else begin
            flashRead <= issueRead;
            if (issueRead) begin
                flashAddr <= scanAddr;
            end
        end
    end

    // The byte is taken FLASH_LAT cycles after its strobe; a clear drops reads still in flight.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            readPipe   <= '0;
            flashValid <= 1'b0;
            flashByte  <= 8'h00;
        end else begin
            readPipe   <= clearReq ? '0 : (readPipe << 1) | LAT'(flashRead & selFlash);
            flashValid <= readPipe[LAT-1] & selFlash & !clearReq;
            flashByte  <= flashData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            scanBusy <= 1'b0;
            scanDone <= 1'b0;
        end else begin
            scanBusy <= (next_scanState != crc_pkg::SCAN_IDLE);
            scanDone <= (scanState == crc_pkg::SCAN_DONE);
        end
    end
endmodule

// *** crc_pkg.sv ***
// Package with the constants shared by the checksum generator and its input buffer.
package crc_pkg;

    // Generator polynomials, written without the leading term.
    localparam logic [15:0] POLY16      = 16'h1021;
    localparam logic [31:0] POLY32      = 32'h04c11db7;

    // Seed loaded on a clear, all ones for both widths.
    localparam logic [31:0] SEED        = 32'hffffffff;

    // Reset values of the working state.
    localparam logic [31:0] CHECK_RESET = 32'hffffffff;

    // Source select codes.
    typedef enum logic [1:0] {
        SRC_IO    = 2'b00,
        SRC_DMA   = 2'b01,
        SRC_FLASH = 2'b10,
        SRC_NONE  = 2'b11
    } source_t;

    // Flash scanner states.
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'b00,
        SCAN_REQ  = 2'b01,
        SCAN_WAIT = 2'b10,
        SCAN_DONE = 2'b11
    } scan_t;

    // Input buffer depth and data width.
    localparam int FIFO_DEPTH   = 8;
    localparam int DATA_WIDTH   = 8;

    // Flash read latency in cycles after the read strobe.
    localparam int FLASH_LAT    = 1;

endpackage

// *** crc_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module crc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic             flush,
    // Filling side
    input  wire logic [WIDTH-1:0] inData,
    input  wire logic             inValid,
    output logic                  inReady,
    // Draining side
    output logic      [WIDTH-1:0] outData,
    output logic                  outValid,
    input  wire logic             outReady
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr;
    logic [AW-1:0]    rdPtr;
    logic [AW:0]      count;

    wire doWrite = inValid & inReady;
    wire doRead  = outValid & outReady;

    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    always_ff @(posedge mclk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst || flush) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (doWrite) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (doRead) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(doWrite) - (AW+1)'(doRead);
        end
    end
endmodule

// *** flash_model.sv ***
// Flash memory model for the scanner's read port.
`timescale 1ns/100ps
module flash_model #(
    parameter int AW = 4
) (
    input  wire logic          mclk,
    input  wire logic [AW-1:0] flashAddr,
    input  wire logic          flashRead,
    output logic      [7:0]    flashData
);
    logic [7:0] last = 8'h00;
    // Data is good only in the cycle after the strobe; later it flips so stale use shows.
    always_ff @(posedge mclk) begin
        last <= flashRead ? 8'(flashAddr * 37 + 5) : ~last;
    end
    assign flashData = last;
endmodule

// *** crc_generator_sva.sv ***
// Port assertions for the checksum generator.
`timescale 1ns/100ps
module crc_generator_sva #(
    parameter int ADDR_WIDTH = 17,
    parameter int FLASH_SIZE = 131072
) (
    input wire logic                  mclk,
    input wire logic                  sys_rst,
    input wire logic                  polySel32,
    input wire logic [1:0]            sourceSel,
    input wire logic                  clearReq,
    input wire logic                  ioReady,
    input wire logic                  dmaReady,
    input wire logic                  scanStart,
    input wire logic                  scanWhole,
    input wire logic [ADDR_WIDTH-1:0] scanFirst,
    input wire logic [ADDR_WIDTH-1:0] scanLast,
    input wire logic                  scanBusy,
    input wire logic [ADDR_WIDTH-1:0] flashAddr,
    input wire logic                  flashRead,
    input wire logic [31:0]           checksum,
    input wire logic                  zeroRemainder
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence s_take;
        scanStart && !scanBusy && sourceSel == 2'b10 && !clearReq;
    endsequence
    sequence s_clear32;
        clearReq && polySel32 ##1 !clearReq;
    endsequence
    a_io_refused: assert property (sourceSel != 2'b00 |-> !ioReady)
        else $error("io ready while io not selected");
    a_dma_refused: assert property (sourceSel != 2'b01 |-> !dmaReady)
        else $error("dma ready while dma not selected");
    a_clear_seed: assert property (s_clear32 |-> ##[0:2] checksum == 32'hffffffff)
        else $error("seed not loaded after clear");
    a_upper_zero: assert property (!polySel32 [*3] |-> checksum[31:16] == 16'h0000)
        else $error("upper half set in short mode");
    a_zero_flag: assert property (zeroRemainder |-> checksum == 32'h00000000)
        else $error("zero flag with nonzero remainder");
    a_read_spacing: assert property (flashRead |=> !flashRead)
        else $error("flash reads back to back");
    a_read_range: assert property (flashRead |->
        (scanWhole ? flashAddr <= FLASH_SIZE - 1 :
        flashAddr >= scanFirst && flashAddr <= scanLast))
        else $error("flash read outside range");
    a_read_busy: assert property (flashRead |-> scanBusy)
        else $error("flash read while scanner idle");
    a_scan_start: assert property (s_take |-> ##[1:3] flashRead)
        else $error("scan start gave no read");
endmodule
bind crc_generator crc_generator_sva #(.ADDR_WIDTH(ADDR_WIDTH), .FLASH_SIZE(FLASH_SIZE))
    i_crc_generator_sva (.mclk, .sys_rst, .polySel32, .sourceSel, .clearReq, .ioReady,
    .dmaReady, .scanStart, .scanWhole, .scanFirst, .scanLast, .scanBusy, .flashAddr,
    .flashRead, .checksum, .zeroRemainder);

// *** crc_generator_test.sv ***
// Self-checking bench for the checksum generator and its input buffer.
`timescale 1ns/100ps
module crc_generator_test;
    logic        mclk = 1'b0, sys_rst = 1'b1, polySel32 = 1'b0, clearReq = 1'b0;
    logic [1:0]  sourceSel = 2'b00;
    logic [7:0]  ioData = 8'h00, dmaData = 8'h00, flashData;
    logic        ioWrite = 1'b0, dmaValid = 1'b0, scanStart = 1'b0, scanWhole = 1'b0;
    logic [3:0]  scanFirst = 4'h0, scanLast = 4'h0, flashAddr;
    logic        ioReady, dmaReady, scanBusy, scanDone, flashRead, zeroRemainder, busy;
    logic [31:0] checksum, exp, seed = 32'hb533;
    int          failures = 0, cmp_count = 0;
    always #25 mclk = ~mclk;
    crc_generator #(.ADDR_WIDTH(4), .FLASH_SIZE(16)) i_crc_generator (.mclk, .sys_rst,
        .polySel32, .sourceSel, .clearReq, .ioData, .ioWrite, .ioReady, .dmaData, .dmaValid,
        .dmaReady, .scanStart, .scanWhole, .scanFirst, .scanLast, .scanBusy, .scanDone,
        .flashAddr, .flashRead, .flashData, .checksum, .zeroRemainder, .busy);
    flash_model #(.AW(4)) i_flash_model (.mclk, .flashAddr, .flashRead, .flashData);
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // Reference fold, msb first; the short form is masked at the end only.
    function automatic logic [31:0] nxt(logic [31:0] c, logic [7:0] d, logic w);
        for (int i = 7; i >= 0; i--) begin
            if (w) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? crc_pkg::POLY32 : 32'h0);
            else c = {c[30:0], 1'b0} ^ ((c[15] ^ d[i]) ? {16'h0, crc_pkg::POLY16} : 32'h0);
        end
        return w ? c : {16'h0000, c[15:0]};
    endfunction
    task automatic chk(string n, logic [31:0] s, logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", n, e, s);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic lim(int k);
        if (k >= 200) begin
            failures++;
            complete_run();
        end
    endtask
    task automatic clr(logic w);
        polySel32 = w;
        clearReq = 1'b1;
        @(negedge mclk) clearReq = 1'b0;
        exp = w ? 32'hffffffff : 32'h0000ffff;
        repeat (3) @(negedge mclk);
        chk("seed", checksum, exp);
    endtask
    // The byte is held until ready is seen, then one edge passes to take it.
    task automatic feed(logic d, logic [7:0] b);
        int k;
        {dmaData, dmaValid, ioData, ioWrite} = {b, d, b, !d};
        #1;
        for (k = 0; k < 200 && !(d ? dmaReady : ioReady); k++) @(negedge mclk) #1;
        lim(k);
        @(negedge mclk);
        exp = nxt(exp, b, polySel32);
    endtask
    task automatic idle();
        {ioWrite, dmaValid} = 2'b00;
        repeat (4) @(negedge mclk);
    endtask
    task automatic run(logic w, logic d, int n);
        logic [31:0] c;
        sourceSel = {1'b0, d};
        clr(w);
        chk("ioReady", ioReady, !d);
        chk("dmaReady", dmaReady, d);
        for (int i = 0; i < n; i++) feed(d, rnd());
        chk("busy", busy, 1);
        idle();
        chk("idle", busy, 0);
        c = exp;
        chk("crc", checksum, c);
        chk("flag", zeroRemainder, c == 0);
        for (int i = w ? 24 : 8; i >= 0; i -= 8) feed(d, c[i+:8]);
        idle();
        chk("zero", zeroRemainder, 1);
        chk("rem", checksum, 0);
        $display("stream test done: wide %0d dma %0d", w, d);
    endtask
    task automatic scan(logic wh, logic [3:0] a, logic [3:0] b);
        int k;
        sourceSel = 2'b10;
        clr(1'b1);
        {scanWhole, scanFirst, scanLast, scanStart} = {wh, a, b, 1'b1};
        @(negedge mclk) scanStart = 1'b0;
        chk("scanBusy", scanBusy, 1);
        for (k = wh ? 0 : a; k <= (wh ? 15 : b); k++) exp = nxt(exp, 8'(k * 37 + 5), 1'b1);
        for (k = 0; k < 200 && scanDone !== 1'b1; k++) @(negedge mclk);
        lim(k);
        @(negedge mclk);
        chk("scanDone", scanDone, 0);
        repeat (3) @(negedge mclk);
        chk("scan", checksum, exp);
        chk("scanIdle", scanBusy, 0);
        $display("scan test done: whole %0d", wh);
    endtask
    // With no source selected, offered bytes must be refused and the checksum must stand.
    task automatic none_test();
        sourceSel = 2'b11;
        clr(1'b0);
        {dmaData, dmaValid, ioData, ioWrite} = {8'h5a, 1'b1, 8'ha5, 1'b1};
        #1;
        chk("ioReady", ioReady, 0);
        chk("dmaReady", dmaReady, 0);
        repeat (3) @(negedge mclk);
        chk("busy", busy, 0);
        idle();
        chk("held", checksum, 32'h0000ffff);
        $display("idle source test done");
    endtask
    initial begin
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        @(negedge mclk);
        chk("reset", checksum, 32'h0000ffff);
        none_test();
        run(1'b0, 1'b0, 12);
        run(1'b1, 1'b0, 12);
        run(1'b0, 1'b1, 9);
        run(1'b1, 1'b1, 10);
        scan(1'b0, 4'h3, 4'h9);
        scan(1'b1, 4'h9, 4'h2);
        complete_run();
    end
endmodule
